// [logic/isp_port_defines.vh]
// constants for the serial programming port
`ifndef ISP_PORT_DEFINES_VH
`define ISP_PORT_DEFINES_VH
`define ISP_PREFIX_ENABLE 8'hac
`define ISP_ENABLE_SECOND 8'h53
`define ISP_ERASE_TOP3 3'b100
`define ISP_LOCK_TOP3 3'b111
`define ISP_FUSE_LOW_SECOND 8'ha0
`define ISP_FUSE_HIGH_SECOND 8'ha8
`define ISP_RD_PROG_TOP 4'h2
`define ISP_LD_PAGE_TOP 4'h4
`define ISP_WR_PAGE 8'h4c
`define ISP_RD_EEPROM 8'ha0
`define ISP_WR_EEPROM 8'hc0
`define ISP_RD_LOCK 8'h58
`define ISP_RD_SIG 8'h30
`define ISP_RD_FUSE 8'h50
`define ISP_RD_CAL 8'h38
`define ISP_ERASED_BYTE 8'hff
`define ISP_CLK_MHZ 100
`define ISP_FLASH_WAIT_US 4500
`define ISP_EEPROM_WAIT_US 9000
`define ISP_FUSE_WAIT_US 4500
`define ISP_ERASE_WAIT_US 9000
`define ISP_FLASH_WAIT_CYC (`ISP_FLASH_WAIT_US * `ISP_CLK_MHZ)
`define ISP_EEPROM_WAIT_CYC (`ISP_EEPROM_WAIT_US * `ISP_CLK_MHZ)
`define ISP_ERASE_WAIT_CYC (`ISP_ERASE_WAIT_US * `ISP_CLK_MHZ)
`define ISP_FUSE_WAIT_CYC (`ISP_FUSE_WAIT_US * `ISP_CLK_MHZ)
`endif

// [logic/pin_sync.v]
// two-stage synchroniser for a group of pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
    parameter WIDTH = 2
) (
    input wire core_clk_in,
    input wire rst_b_in,
    input wire [WIDTH-1:0] async_in,
    output wire [WIDTH-1:0] sync_out
);
    reg [WIDTH-1:0] stage1;
    reg [WIDTH-1:0] stage2;
    genvar i;
    // each bit gets its own pair; stage1 is read by stage2 only
    generate
        for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
            always @(posedge core_clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                end else begin
                    stage1[i] <= async_in[i];
                    stage2[i] <= stage1[i];
                end
            end
        end
    endgenerate
    assign sync_out = stage2;
endmodule
`default_nettype wire

// [logic/write_timer.v]
// busy timer for self-timed nonvolatile writes
`timescale 1ns/10ps
`default_nettype none
module write_timer #(
    parameter CW = 20
) (
    input wire core_clk_in,
    input wire rst_b_in,
    input wire start_in,
    input wire [CW-1:0] cycles_in,
    output wire busy_out,
    output wire done_out
);
    reg [CW-1:0] remain;
    reg done;
    // loads on start, counts to zero, pulses done in the cycle the count reaches zero
    always @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            remain <= {CW{1'b0}};
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start_in) begin
                remain <= cycles_in;
            end else if (remain != {CW{1'b0}}) begin
                remain <= remain - 1'b1;
                done <= (remain == {{(CW-1){1'b0}}, 1'b1});
            end
        end
    end
    assign busy_out = (remain != {CW{1'b0}});
    assign done_out = done;
endmodule
`default_nettype wire

// [logic/serial_isp_programming_port.v]
// serial in-system programming port: link, instruction decoder, memories
`timescale 1ns/10ps
`default_nettype none
`include "isp_port_defines.vh"
module serial_isp_programming_port #(
    parameter FLASH_AW = 12,
    parameter PAGE_AW = 5,
    parameter EEPROM_AW = 9,
    parameter CW = 20,
    parameter [CW-1:0] FLASH_WAIT_CYC = `ISP_FLASH_WAIT_CYC,
    parameter [CW-1:0] EEPROM_WAIT_CYC = `ISP_EEPROM_WAIT_CYC,
    parameter [CW-1:0] FUSE_WAIT_CYC = `ISP_FUSE_WAIT_CYC,
    parameter [CW-1:0] ERASE_WAIT_CYC = `ISP_ERASE_WAIT_CYC,
    parameter [7:0] SIG_BYTE0 = 8'h11, // arbitrary value
    parameter [7:0] SIG_BYTE1 = 8'h22, // arbitrary value
    parameter [7:0] SIG_BYTE2 = 8'h33, // arbitrary value
    parameter [7:0] CAL_BYTE = 8'h80
) (
    input wire core_clk_in,
    input wire rst_b_in,
    input wire chip_reset_pin_in,
    input wire serial_clock_port_pin_in,
    input wire serial_in_port_pin_in,
    output reg serial_out_port_pin_out,
    output wire prog_mode_out,
    output wire write_busy_out
);
    localparam FLASH_WORDS = 1 << FLASH_AW;
    localparam PAGE_WORDS = 1 << PAGE_AW;
    localparam EEPROM_BYTES = 1 << EEPROM_AW;
    localparam NPAGE = FLASH_AW - PAGE_AW;
    // busy kinds
    localparam BK_NONE = 2'd0;
    localparam BK_PAGE = 2'd1;
    localparam BK_EEP = 2'd2;
    localparam BK_OTHER = 2'd3;

    reg [15:0] flash_mem [0:FLASH_WORDS-1];
    reg [15:0] page_buf [0:PAGE_WORDS-1];
    reg [7:0] eeprom_mem [0:EEPROM_BYTES-1];
    reg [7:0] fuse_low;
    reg [7:0] fuse_high;
    reg [5:0] lock_bits;

    wire [2:0] synced;
    reg sck_prev;
    reg [7:0] shift_in;
    reg [2:0] bit_cnt;
    reg [1:0] byte_idx;
    reg [7:0] b1;
    reg [7:0] b2;
    reg [7:0] b3;
    reg [7:0] tx_byte;
    reg enabled;
    reg [1:0] busy_kind;
    reg [NPAGE-1:0] busy_page;
    reg [EEPROM_AW-1:0] busy_eaddr;
    reg [7:0] busy_edata;
    reg erase_go;
    reg timer_start;
    reg [CW-1:0] timer_cycles;
    wire timer_busy;
    wire timer_done;
    integer k;

    // reset pin, sck and mosi all come from outside the clock domain;
    // the reset pin enters inverted so that the cleared synchroniser
    // reads as pin high and no programming window opens at power-on
    pin_sync #(
        .WIDTH(3)
    ) u_sync (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .async_in({~chip_reset_pin_in, serial_clock_port_pin_in, serial_in_port_pin_in}),
        .sync_out(synced)
    );
    wire reset_low = synced[2];
    wire sck_s = synced[1];
    wire mosi_s = synced[0];
    wire sck_rise = reset_low & sck_s & ~sck_prev;
    wire sck_fall = reset_low & ~sck_s & sck_prev;
    wire byte_done = sck_rise & (bit_cnt == 3'd7);
    wire [7:0] rx_byte = {shift_in[6:0], mosi_s};

    write_timer #(
        .CW(CW)
    ) u_timer (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .start_in(timer_start),
        .cycles_in(timer_cycles),
        .busy_out(timer_busy),
        .done_out(timer_done)
    );
    assign write_busy_out = timer_busy;
    assign prog_mode_out = enabled;

    // decoded fields of a completed instruction (fourth byte is rx_byte)
    wire [15:0] addr_full = {b2, b3};
    wire [FLASH_AW-1:0] word_addr = addr_full[FLASH_AW-1:0];
    wire [EEPROM_AW-1:0] ee_addr = {b2[0], b3};
    wire [PAGE_AW-1:0] page_word = b3[PAGE_AW-1:0];
    wire [NPAGE-1:0] word_page = word_addr[FLASH_AW-1:PAGE_AW];
    wire is_enable = (b1 == `ISP_PREFIX_ENABLE) && (b2 == `ISP_ENABLE_SECOND);
    wire is_erase = (b1 == `ISP_PREFIX_ENABLE) && (b2[7:5] == `ISP_ERASE_TOP3);

    // flash read value, ones while its page is being written
    reg [7:0] flash_rd;
    reg [7:0] ee_rd;
    always @* begin
        flash_rd = b1[3] ? flash_mem[word_addr][15:8] : flash_mem[word_addr][7:0];
        if (busy_kind == BK_PAGE && word_page == busy_page) begin
            flash_rd = `ISP_ERASED_BYTE;
        end
        ee_rd = eeprom_mem[ee_addr];
        if (busy_kind == BK_EEP && ee_addr == busy_eaddr) begin
            ee_rd = `ISP_ERASED_BYTE;
        end
    end

    // read data for the fourth byte, chosen once the third is in
    reg [7:0] read_val;
    always @* begin
        read_val = 8'h00;
        case (b1)
            `ISP_RD_EEPROM: read_val = ee_rd;
            `ISP_RD_LOCK: read_val = (b2 == 8'h08) ? fuse_high : {2'b11, lock_bits};
            `ISP_RD_FUSE: read_val = fuse_low;
            `ISP_RD_CAL: read_val = CAL_BYTE;
            `ISP_RD_SIG: read_val = (b3[1:0] == 2'd0) ? SIG_BYTE0 :
                (b3[1:0] == 2'd1) ? SIG_BYTE1 : SIG_BYTE2;
            default: begin
                if (b1[7:4] == `ISP_RD_PROG_TOP && b1[2:0] == 3'd0) begin
                    read_val = flash_rd;
                end
            end
        endcase
    end

    // link: sample on rising sck, count bits and bytes, msb first
    always @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sck_prev <= 1'b0;
            shift_in <= 8'h00;
            bit_cnt <= 3'd0;
            byte_idx <= 2'd0;
            b1 <= 8'h00;
            b2 <= 8'h00;
            b3 <= 8'h00;
        end else if (!reset_low) begin
            sck_prev <= 1'b0;
            bit_cnt <= 3'd0;
            byte_idx <= 2'd0;
        end else begin
            sck_prev <= sck_s;
            if (sck_rise) begin
                shift_in <= rx_byte;
                bit_cnt <= bit_cnt + 3'd1;
            end
            if (byte_done) begin
                byte_idx <= byte_idx + 2'd1;
                case (byte_idx)
                    2'd0: b1 <= rx_byte;
                    2'd1: b2 <= rx_byte;
                    2'd2: b3 <= rx_byte;
                    default: b3 <= b3;
                endcase
            end
        end
    end

    // miso: load a byte at each byte boundary, shift on falling sck
    always @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tx_byte <= 8'h00;
            serial_out_port_pin_out <= 1'b0;
        end else if (!reset_low) begin
            tx_byte <= 8'h00;
            serial_out_port_pin_out <= 1'b0;
        end else if (byte_done) begin
            // echo of byte 2 shifts out during byte 3; read data in byte 4
            case (byte_idx)
                2'd0: tx_byte <= 8'h00;
                2'd1: tx_byte <= rx_byte;
                2'd2: tx_byte <= b2;
                default: tx_byte <= 8'h00;
            endcase
        end else if (byte_idx == 2'd3 && bit_cnt == 3'd0 && sck_fall) begin
            serial_out_port_pin_out <= read_val[7];
            tx_byte <= {read_val[6:0], 1'b0};
        end else if (sck_fall) begin
            serial_out_port_pin_out <= tx_byte[7];
            tx_byte <= {tx_byte[6:0], 1'b0};
        end
    end

    // execute a complete instruction; control state, fuses and lock bits are reset, the memories are not
    always @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            enabled <= 1'b0;
            busy_kind <= BK_NONE;
            busy_page <= {NPAGE{1'b0}};
            busy_eaddr <= {EEPROM_AW{1'b0}};
            busy_edata <= 8'h00;
            erase_go <= 1'b0;
            timer_start <= 1'b0;
            timer_cycles <= {CW{1'b0}};
            fuse_low <= 8'hff;
            fuse_high <= 8'hff;
            lock_bits <= 6'h3f;
        end else begin
            timer_start <= 1'b0;
            erase_go <= 1'b0;
            if (!reset_low) begin
                enabled <= 1'b0;
            end
            if (timer_done) begin
                // commit a pending eeprom write at the end of the self-timed wait; flash pages land at once
                busy_kind <= BK_NONE;
                if (busy_kind == BK_EEP) begin
                    eeprom_mem[busy_eaddr] <= busy_edata;
                end
            end
            // erase lands after any commit above, so a write that retires
            // in the same cycle cannot survive a later chip erase
            if (erase_go) begin
                for (k = 0; k < FLASH_WORDS; k = k + 1) begin
                    flash_mem[k] <= {2{`ISP_ERASED_BYTE}};
                end
                for (k = 0; k < EEPROM_BYTES; k = k + 1) begin
                    eeprom_mem[k] <= `ISP_ERASED_BYTE;
                end
            end
            if (byte_done && byte_idx == 2'd3) begin
                if (is_enable) begin
                    enabled <= 1'b1;
                end else if (enabled && is_erase) begin
                    erase_go <= 1'b1;
                    busy_kind <= BK_OTHER;
                    timer_cycles <= ERASE_WAIT_CYC;
                    timer_start <= 1'b1;
                end else if (enabled && b1 == `ISP_PREFIX_ENABLE) begin
                    busy_kind <= BK_OTHER;
                    timer_cycles <= FUSE_WAIT_CYC;
                    timer_start <= 1'b1;
                    if (b2[7:5] == `ISP_LOCK_TOP3) begin
                        lock_bits <= rx_byte[5:0];
                    end else if (b2 == `ISP_FUSE_LOW_SECOND) begin
                        fuse_low <= rx_byte;
                    end else if (b2 == `ISP_FUSE_HIGH_SECOND) begin
                        fuse_high <= rx_byte;
                    end
                end else if (enabled && b1[7:4] == `ISP_LD_PAGE_TOP && b1[2:0] == 3'd0) begin
                    if (b1[3]) begin
                        page_buf[page_word][15:8] <= rx_byte;
                    end else begin
                        page_buf[page_word][7:0] <= rx_byte;
                    end
                end else if (enabled && b1 == `ISP_WR_PAGE) begin
                    // the page lands at once; reads of it show ones until the timer ends
                    for (k = 0; k < PAGE_WORDS; k = k + 1) begin
                        flash_mem[{word_page, k[PAGE_AW-1:0]}] <= page_buf[k];
                    end
                    busy_kind <= BK_PAGE;
                    busy_page <= word_page;
                    timer_cycles <= FLASH_WAIT_CYC;
                    timer_start <= 1'b1;
                end else if (enabled && b1 == `ISP_WR_EEPROM) begin
                    // whole-byte overwrite: the location is erased then written
                    busy_kind <= BK_EEP;
                    busy_eaddr <= ee_addr;
                    busy_edata <= rx_byte;
                    timer_cycles <= EEPROM_WAIT_CYC;
                    timer_start <= 1'b1;
                end
            end
        end
    end

endmodule
`default_nettype wire

// [verif/isp_port_checker_assertions.sv]
// checker for the serial programming port, bound to the top module
`timescale 1ns/10ps
`default_nettype none
module isp_port_checker #(
    parameter int CW = 20,
    parameter logic [CW-1:0] FLASH_WAIT_CYC = 20'h00001,
    parameter logic [CW-1:0] ERASE_WAIT_CYC = 20'h00001
) (
    input wire logic core_clk_in,
    input wire logic rst_b_in,
    input wire logic chip_reset_pin_in,
    input wire logic serial_clock_port_pin_in,
    input wire logic serial_in_port_pin_in,
    input wire logic serial_out_port_pin_out,
    input wire logic prog_mode_out,
    input wire logic write_busy_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!rst_b_in);
    logic sck_q;
    logic [7:0] fall_age;
    logic [7:0] rise_age;
    logic [2:0] pin_age;
    logic [CW:0] busy_len;
    // ages since raw pin edges; saturate so a long idle never wraps
    always_ff @(posedge core_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sck_q <= 1'b0;
            fall_age <= 8'hff;
            rise_age <= 8'hff;
            pin_age <= 3'h0;
            busy_len <= '0;
        end else begin
            sck_q <= serial_clock_port_pin_in;
            if (sck_q && !serial_clock_port_pin_in) fall_age <= 8'h00;
            else if (fall_age != 8'hff) fall_age <= fall_age + 8'h01;
            if (!sck_q && serial_clock_port_pin_in) rise_age <= 8'h00;
            else if (rise_age != 8'hff) rise_age <= rise_age + 8'h01;
            if (chip_reset_pin_in) pin_age <= 3'h0;
            else if (pin_age != 3'h7) pin_age <= pin_age + 3'h1;
            busy_len <= write_busy_out ? busy_len + 1'b1 : '0;
        end
    end
    a_mode_needs_pin: assert property (chip_reset_pin_in [*4] |-> !prog_mode_out)
        else $error("programming mode held while reset pin high");
    a_miso_quiet_pin: assert property (chip_reset_pin_in [*5] |-> !serial_out_port_pin_out)
        else $error("data out not cleared while reset pin high");
    // with the reset pin held low, data out moves only a few clocks after a falling serial clock
    a_miso_on_fall: assert property ($changed(serial_out_port_pin_out) && pin_age == 3'h7
        |-> fall_age inside {[1:5]}) else $error("data out changed away from falling clock");
    a_mode_rise_frame: assert property ($rose(prog_mode_out)
        |-> !chip_reset_pin_in && rise_age inside {[1:6]}) else $error("mode rose outside frame end");
    a_mode_drop_cause: assert property ($fell(prog_mode_out) |-> pin_age < 3'h6)
        else $error("mode dropped without reset pin");
    a_busy_needs_mode: assert property ($rose(write_busy_out) |-> prog_mode_out)
        else $error("write started outside programming mode");
    a_busy_after_frame: assert property ($rose(write_busy_out) |-> rise_age inside {[1:6]})
        else $error("write started away from frame end");
    // lower bound is the shortest wait (flash page), upper the chip erase
    a_busy_span_len: assert property ($fell(write_busy_out)
        |-> busy_len + 2 >= FLASH_WAIT_CYC && busy_len <= ERASE_WAIT_CYC + 2)
        else $error("write busy span out of range");
    c_mode_on: cover property ($rose(prog_mode_out));
    c_busy_on: cover property ($rose(write_busy_out));
    c_busy_off: cover property ($fell(write_busy_out));
endmodule
bind serial_isp_programming_port isp_port_checker #(
    .FLASH_WAIT_CYC(FLASH_WAIT_CYC),
    .ERASE_WAIT_CYC(ERASE_WAIT_CYC)
) i_chk (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .chip_reset_pin_in(chip_reset_pin_in),
    .serial_clock_port_pin_in(serial_clock_port_pin_in),
    .serial_in_port_pin_in(serial_in_port_pin_in),
    .serial_out_port_pin_out(serial_out_port_pin_out),
    .prog_mode_out(prog_mode_out),
    .write_busy_out(write_busy_out)
);
`default_nettype wire

// [verif/isp_programmer.sv]
// model of the external programmer driving the serial pins
`timescale 1ns/10ps
`default_nettype none
module isp_programmer (
    input wire logic core_clk_in,
    input wire logic miso_in,
    output logic sck_out,
    output logic mosi_out,
    output logic chip_reset_out
);
    localparam int PHASE = 8;
    initial begin
        sck_out = 1'b0;
        mosi_out = 1'b0;
        chip_reset_out = 1'b1;
    end
    // every pin change lands just after a rising clock edge
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    // sck low first, then a reset pulse; settle wait is shortened
    task automatic power_up();
        sck_out = 1'b0;
        chip_reset_out = 1'b1;
        tick(3);
        chip_reset_out = 1'b0;
        tick(20);
    endtask
    task automatic release_pin();
        chip_reset_out = 1'b1;
        tick(6);
    endtask
    // one whole four-byte frame, msb first; sck idles low between frames
    task automatic xfer(input logic [31:0] tx, output logic [31:0] rx);
        for (int i = 31; i >= 0; i--) begin
            mosi_out = tx[i];
            tick(PHASE);
            rx[i] = miso_in;
            sck_out = 1'b1;
            tick(PHASE);
            sck_out = 1'b0;
        end
        tick(1);
        mosi_out = ~tx[0]; // no stale bit left on the line
    endtask
endmodule
`default_nettype wire

// [verif/tb_serial_isp_programming_port.sv]
// self-checking bench for the serial programming port
`timescale 1ns/10ps
`default_nettype none
module tb_serial_isp_programming_port;
    logic core_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic chip_reset, sck, mosi, miso, prog_mode, busy;
    logic [31:0] rx;
    int err_total = 0;
    int compares = 0;
    always #5 core_clk_in = ~core_clk_in;
    // waits shortened, yet long enough for a read frame inside a busy span;
    // the fuse wait keeps its default since no scenario writes fuses
    serial_isp_programming_port #(
        .FLASH_WAIT_CYC(20'h004b0),
        .EEPROM_WAIT_CYC(20'h005dc),
        .ERASE_WAIT_CYC(20'h00708)
    ) i_dut (
        .core_clk_in(core_clk_in),
        .rst_b_in(rst_b_in),
        .chip_reset_pin_in(chip_reset),
        .serial_clock_port_pin_in(sck),
        .serial_in_port_pin_in(mosi),
        .serial_out_port_pin_out(miso),
        .prog_mode_out(prog_mode),
        .write_busy_out(busy)
    );
    isp_programmer i_prog (
        .core_clk_in(core_clk_in),
        .miso_in(miso),
        .sck_out(sck),
        .mosi_out(mosi),
        .chip_reset_out(chip_reset)
    );
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask
    task automatic cmd(input logic [31:0] tx);
        i_prog.xfer(tx, rx);
    endtask
    // bounded wait for the self-timed write to finish
    task automatic wait_idle();
        int n;
        n = 0;
        while (busy !== 1'b0 && n < 4000) begin
            i_prog.tick(1);
            n++;
        end
        check("busy end", 1'b0, busy);
    endtask
    task automatic t_before_enable();
        i_prog.power_up();
        cmd(32'hac80_0000);
        cmd(32'hc001_105a);
        check("busy before enable", 1'b0, busy);
        check("mode before enable", 1'b0, prog_mode);
        $display("test before_enable done");
    endtask
    // a garbled enable first, then the reset pulse and a clean retry
    task automatic t_enable();
        cmd(32'h5629_8000);
        check("mode after garble", 1'b0, prog_mode);
        i_prog.power_up();
        cmd(32'hac53_0000);
        check("echo", 8'h53, rx[15:8]);
        i_prog.tick(6);
        check("mode", 1'b1, prog_mode);
        $display("test enable done");
    endtask
    task automatic t_erase();
        cmd(32'hac80_0000);
        check("erase busy", 1'b1, busy);
        wait_idle();
        cmd(32'h2001_6300);
        check("erased flash", 8'hff, rx[7:0]);
        cmd(32'ha001_1000);
        check("erased eeprom", 8'hff, rx[7:0]);
        $display("test erase done");
    endtask
    // later writes overwrite without erase: clears and sets bits; the last
    // writes ones, which polling cannot see, so the full wait is kept
    task automatic t_eeprom();
        logic [7:0] d [3] = '{8'h5a, 8'ha5, 8'hff};
        for (int i = 0; i < 3; i++) begin
            cmd({24'hc001_10, d[i]});
            check("eeprom busy", 1'b1, busy);
            cmd(32'ha001_1000);
            check("eeprom poll", 8'hff, rx[7:0]);
            wait_idle();
            cmd(32'ha001_1000);
            check("eeprom data", d[i], rx[7:0]);
        end
        $display("test eeprom done");
    endtask
    task automatic t_flash();
        cmd(32'h4000_0312);
        cmd(32'h4800_0334);
        cmd(32'h4c01_6000);
        check("page busy", 1'b1, busy);
        cmd(32'h2001_6300);
        check("page poll", 8'hff, rx[7:0]);
        wait_idle();
        cmd(32'h2001_6300);
        check("flash low", 8'h12, rx[7:0]);
        cmd(32'h2801_6300);
        check("flash high", 8'h34, rx[7:0]);
        $display("test flash done");
    endtask
    // identification and fuse reads need no wait
    task automatic t_ident();
        cmd(32'h3000_0100);
        check("signature", 8'h22, rx[7:0]);
        cmd(32'h3800_0000);
        check("calibration", 8'h80, rx[7:0]);
        cmd(32'h5808_0000);
        check("fuse high", 8'hff, rx[7:0]);
        $display("test ident done");
    endtask
    task automatic t_exit();
        i_prog.release_pin();
        check("mode after release", 1'b0, prog_mode);
        cmd(32'hc001_1077);
        check("busy with pin high", 1'b0, busy);
        rst_b_in = 1'b0;
        i_prog.tick(2);
        rst_b_in = 1'b1;
        check("mode after reset", 1'b0, prog_mode);
        $display("test exit done");
    endtask
    task automatic stop_test();
        $display("comparisons %0d, errors %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        i_prog.tick(8);
        rst_b_in = 1'b1;
        t_before_enable();
        t_enable();
        t_erase();
        t_eeprom();
        t_flash();
        t_ident();
        t_exit();
        stop_test();
    end
    // watchdog: the scenarios need about 20000 cycles
    initial begin
        repeat (60000) @(posedge core_clk_in);
        err_total++;
        stop_test();
    end
endmodule
`default_nettype wire
